// ==== hdl/ioag_pkg.sv ====
// Package of constants for the indexed offset address generator
package ioag_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned DATA_ADDR_W = 12;   // 4096-byte data space
  localparam int unsigned FILE_W      = 8;    // File operand field
  localparam int unsigned BANK_W      = 4;    // Bank select width

  // ****************************************************************
  // Address map constants
  // ****************************************************************
  localparam logic [FILE_W-1:0]      OFFSET_LIMIT    = 8'h5f;  // Top remapped operand
  localparam logic [FILE_W-1:0]      ACCESS_SPLIT    = 8'h60;  // Low/high access half
  localparam logic [BANK_W-1:0]      ACCESS_HI_BANK  = 4'hf;   // Upper access half bank
  localparam logic [BANK_W-1:0]      ACCESS_LO_BANK  = 4'h0;   // Lower access half bank

  // ****************************************************************
  // Register offsets on the plain register port
  // ****************************************************************
  localparam logic [3:0] REG_CFG      = 4'h0;  // Extension enable bit
  localparam logic [3:0] REG_BANK     = 4'h1;  // Bank select register
  localparam logic [3:0] REG_FP_LO    = 4'h2;  // Frame pointer low byte
  localparam logic [3:0] REG_FP_HI    = 4'h3;  // Frame pointer high nibble
  localparam logic [3:0] REG_STATUS   = 4'h4;  // Last address, low byte
  localparam logic [3:0] REG_STATUS_H = 4'h5;  // Last address high + mode flags

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned CFG_XEN_BIT   = 0;      // Enable bit position
  localparam logic        CFG_XEN_RST   = 1'b0;   // Extension off after reset
  localparam logic [BANK_W-1:0]      BANK_RST = 4'h0;    // Bank select reset
  localparam logic [DATA_ADDR_W-1:0] FP_RST   = 12'h000; // Frame pointer reset

  // ****************************************************************
  // Address mode encoding
  // ****************************************************************
  typedef enum logic [2:0] {
    IOAG_MODE_ACCESS  = 3'b001,  // Literal access bank
    IOAG_MODE_BANKED  = 3'b010,  // Literal banked
    IOAG_MODE_INDEXED = 3'b100   // Frame pointer plus offset
  } ioag_mode_t;

endpackage : ioag_pkg

// ==== hdl/ioag_addr_calc.sv ====
// Combinational effective address calculation for one file operand
module ioag_addr_calc
  import ioag_pkg::*;
(
  // Operand
  input  wire logic [FILE_W-1:0]      file_i,
  input  wire logic                   access_sel_i,
  // Mode and pointers
  input  wire logic                   ext_en_i,
  input  wire logic [BANK_W-1:0]      bank_i,
  input  wire logic [DATA_ADDR_W-1:0] fp_i,
  // Result
  output      logic [DATA_ADDR_W-1:0] addr_o,
  output      ioag_mode_t             mode_o
);

  // ****************************************************************
  // Address selection
  // ****************************************************************
  logic [DATA_ADDR_W-1:0] sum;  // Pointer plus offset, carry dropped

  // Only the low file range is remapped; the carry is dropped on purpose
  always_comb
  begin
    sum = fp_i + {{(DATA_ADDR_W-FILE_W){1'b0}}, file_i};
    if (access_sel_i)
    begin
      // Banked literal, extension has no say here
      addr_o = {bank_i, file_i};
      mode_o = IOAG_MODE_BANKED;
    end
    else if (ext_en_i && (file_i <= OFFSET_LIMIT))
    begin
      // Frame relative; a zero pointer lands on the old access RAM
      addr_o = sum;
      mode_o = IOAG_MODE_INDEXED;
    end
    else
    begin
      // Literal access bank, split into low RAM and high registers
      addr_o = (file_i >= ACCESS_SPLIT) ? {ACCESS_HI_BANK, file_i}
                                        : {ACCESS_LO_BANK, file_i};
      mode_o = IOAG_MODE_ACCESS;
    end
  end

endmodule : ioag_addr_calc

// ==== hdl/ioag_top.sv ====
// Indexed offset address generator for byte and bit oriented operands
//
// The address map and the address-and-strobe port were left to the implementer.
module ioag_top
  import ioag_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   clk_en_i,
  // Decoded operand from instruction decode
  input  wire logic                   op_valid_i,
  input  wire logic                   op_is_byte_i,
  input  wire logic [FILE_W-1:0]      op_file_i,
  input  wire logic                   op_access_sel_i,
  input  wire logic                   op_dest_i,
  // Register port
  input  wire logic [3:0]             reg_addr_i,
  input  wire logic [7:0]             reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output      logic [7:0]             reg_rdata_o,
  // Data memory address path
  output      logic                   addr_valid_o,
  output      logic [DATA_ADDR_W-1:0] addr_o,
  output      logic                   dest_file_o,
  output      logic                   indexed_o,
  output      logic                   ext_en_o
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic                   ext_en_r,  ext_en_nxt;   // Extension enable
  logic [BANK_W-1:0]      bank_r,    bank_nxt;     // Bank select register
  logic [DATA_ADDR_W-1:0] fp_r,      fp_nxt;       // Frame pointer register

  // Software writes steer the address path
  // A write in the same cycle as an operand only reaches the next operand,
  // so the decode never sees a pointer that changes within its own cycle
  // Indices 4 and 5 are status words and ignore writes
  // Hazard: the pointer is written a byte at a time, so software should not
  // let operands run between the two halves of a pointer update
  always_comb
  begin
    ext_en_nxt = ext_en_r;
    bank_nxt   = bank_r;
    fp_nxt     = fp_r;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        REG_CFG:   ext_en_nxt = reg_wdata_i[CFG_XEN_BIT];
        REG_BANK:  bank_nxt   = reg_wdata_i[BANK_W-1:0];
        REG_FP_LO: fp_nxt     = {fp_r[DATA_ADDR_W-1:8], reg_wdata_i};
        REG_FP_HI: fp_nxt     = {reg_wdata_i[DATA_ADDR_W-9:0], fp_r[7:0]};
        default:   ext_en_nxt = ext_en_r;  // Unmapped or read-only: ignored
      endcase
    end
  end

  // Register the configuration; the clock enable freezes it
  // Reset wins over the clock enable so a frozen core still comes up clean
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ext_en_r <= CFG_XEN_RST;
      bank_r   <= BANK_RST;
      fp_r     <= FP_RST;
    end
    else if (clk_en_i)
    begin
      ext_en_r <= ext_en_nxt;
      bank_r   <= bank_nxt;
      fp_r     <= fp_nxt;
    end
  end

  // ****************************************************************
  // Address calculation
  // ****************************************************************
  logic [DATA_ADDR_W-1:0] calc_addr;  // Combinational effective address
  ioag_mode_t             calc_mode;  // Which form was picked

  // Byte and bit forms share one calculator, so they cannot drift apart
  // It works on the registered pointer and bank, never on this cycle's write
  ioag_addr_calc u_calc (
    .file_i       (op_file_i),
    .access_sel_i (op_access_sel_i),
    .ext_en_i     (ext_en_r),
    .bank_i       (bank_r),
    .fp_i         (fp_r),
    .addr_o       (calc_addr),
    .mode_o       (calc_mode)
  );

  // ****************************************************************
  // Output stage
  // ****************************************************************
  logic                   addr_valid_r, addr_valid_nxt;  // Address strobe
  logic [DATA_ADDR_W-1:0] addr_r,       addr_nxt;        // Effective address
  logic                   dest_r,       dest_nxt;        // Destination select
  logic                   indexed_r,    indexed_nxt;     // Indexed form used

  // One cycle of latency; the address is held between operands
  // Holding the address keeps the status read stable while the core idles
  // The strobe itself drops as soon as no operand is offered
  always_comb
  begin
    addr_valid_nxt = op_valid_i;
    addr_nxt       = addr_r;
    dest_nxt       = dest_r;
    indexed_nxt    = indexed_r;
    if (op_valid_i)
    begin
      addr_nxt    = calc_addr;
      // Bit forms have no destination bit; they always write the file
      dest_nxt    = op_is_byte_i ? op_dest_i : 1'b1;
      indexed_nxt = (calc_mode == IOAG_MODE_INDEXED);
    end
  end

  // Register the outputs
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      addr_valid_r <= 1'b0;
      addr_r       <= '0;
      dest_r       <= 1'b0;
      indexed_r    <= 1'b0;
    end
    else if (clk_en_i)
    begin
      addr_valid_r <= addr_valid_nxt;
      addr_r       <= addr_nxt;
      dest_r       <= dest_nxt;
      indexed_r    <= indexed_nxt;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  logic [7:0] rdata_r, rdata_nxt;  // Read data, valid one cycle after strobe

  // Read data only in the cycle after the strobe, zero otherwise
  // Zero outside the read cycle lets several register ports be ORed together
  // Limitation: the status pair is two reads, so it is not sampled atomically
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        REG_CFG:      rdata_nxt = {7'h00, ext_en_r};
        REG_BANK:     rdata_nxt = {4'h0, bank_r};
        REG_FP_LO:    rdata_nxt = fp_r[7:0];
        REG_FP_HI:    rdata_nxt = {4'h0, fp_r[DATA_ADDR_W-1:8]};
        REG_STATUS:   rdata_nxt = addr_r[7:0];
        REG_STATUS_H: rdata_nxt = {2'h0, indexed_r, addr_valid_r, addr_r[DATA_ADDR_W-1:8]};
        default:      rdata_nxt = 8'h00;  // Unmapped reads zero
      endcase
    end
  end

  // Register read data
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      rdata_r <= 8'h00;
    else if (clk_en_i)
      rdata_r <= rdata_nxt;
  end

  // ****************************************************************
  // Outputs, all straight from flip-flops
  // ****************************************************************
  // Nothing combinational reaches a pin, so the core sees clean timing
  assign reg_rdata_o  = rdata_r;
  assign addr_valid_o = addr_valid_r;
  assign addr_o       = addr_r;
  assign dest_file_o  = dest_r;
  assign indexed_o    = indexed_r;
  assign ext_en_o     = ext_en_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Banked literal: bank select on top of the file operand
  a_literal_banked: assert property (
    clk_en_i && op_valid_i && op_access_sel_i |=> addr_o == {$past(bank_r), $past(op_file_i)})
    else $error("banked address wrong");

  // Low access operands stay literal while the extension is off
  a_low_literal: assert property (
    clk_en_i && op_valid_i && !op_access_sel_i && !ext_en_r && op_file_i < ACCESS_SPLIT
    |=> !indexed_o && addr_o == {ACCESS_LO_BANK, $past(op_file_i)})
    else $error("low access operand wrong");

  // Pointer plus offset, carry thrown away
  a_offset_indexed: assert property (
    clk_en_i && op_valid_i && !op_access_sel_i && ext_en_r && op_file_i <= OFFSET_LIMIT
    |=> indexed_o && addr_o == 12'($past(fp_r) + 12'($past(op_file_i))))
    else $error("indexed address wrong");

  // Upper access half is never remapped
  a_high_literal: assert property (
    clk_en_i && op_valid_i && !op_access_sel_i && op_file_i > OFFSET_LIMIT
    |=> !indexed_o && addr_o == {ACCESS_HI_BANK, $past(op_file_i)})
    else $error("high access operand remapped");

  // No extension, no indexed form
  a_ext_off_literal: assert property (
    clk_en_i && op_valid_i && !ext_en_r |=> !indexed_o)
    else $error("indexed without extension");

  // Every operand of either form taken under clock enable is answered exactly one edge later
  a_valid_follows: assert property (
    clk_en_i |=> addr_valid_o == $past(op_valid_i))
    else $error("address strobe out of step");

  // Zero pointer lands on the old access RAM
  a_zero_fp_compat: assert property (
    clk_en_i && op_valid_i && !op_access_sel_i && fp_r == '0 && op_file_i <= OFFSET_LIMIT
    |=> addr_o == {ACCESS_LO_BANK, $past(op_file_i)})
    else $error("zero pointer not compatible");

  // Byte forms pass their destination bit untouched
  a_dest_passes: assert property (
    clk_en_i && op_valid_i && op_is_byte_i |=> dest_file_o == $past(op_dest_i))
    else $error("destination bit altered");

  // Bit forms have no destination bit and always write the file
  a_bit_dest_file: assert property (
    clk_en_i && op_valid_i && !op_is_byte_i |=> dest_file_o)
    else $error("bit form lost its file destination");

  // The enable bit follows the last configuration write
  a_cfg_write: assert property (
    clk_en_i && reg_wr_i && reg_addr_i == REG_CFG |=> ext_en_o == $past(reg_wdata_i[0]))
    else $error("enable bit not written");

  // Bank and pointer writes land at the next edge
  a_bank_write: assert property (
    clk_en_i && reg_wr_i && reg_addr_i == REG_BANK
    |=> bank_r == $past(reg_wdata_i[BANK_W-1:0]))
    else $error("bank select not written");

  a_fp_write: assert property (
    clk_en_i && reg_wr_i && reg_addr_i == REG_FP_LO |=> fp_r[7:0] == $past(reg_wdata_i))
    else $error("pointer low byte not written");

  // The address is held while no operand is offered
  a_addr_held: assert property (
    clk_en_i && !op_valid_i
    |=> $stable(addr_o) && $stable(indexed_o) && $stable(dest_file_o))
    else $error("address moved without an operand");

  // A low clock enable freezes every output
  a_frozen_state: assert property (
    !clk_en_i |=> $stable(addr_o) && $stable(addr_valid_o) && $stable(ext_en_o)
                  && $stable(reg_rdata_o) && $stable(dest_file_o) && $stable(indexed_o))
    else $error("state moved while frozen");

  // Read data stand only in the cycle after the strobe
  a_read_cycle: assert property (
    clk_en_i && !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside its cycle");

  // Status low byte shows the last effective address
  a_status_read: assert property (
    clk_en_i && reg_rd_i && reg_addr_i == REG_STATUS
    |=> reg_rdata_o == $past(addr_r[7:0]))
    else $error("status byte wrong");

  // Unmapped indices read as zero
  a_unmapped_read: assert property (
    clk_en_i && reg_rd_i && reg_addr_i > REG_STATUS_H |=> reg_rdata_o == 8'h00)
    else $error("unmapped index not zero");

  // ****************************************************************
  // Coverage of the main scenarios
  // ****************************************************************
  // Each one marks a case the bench must reach at least once
  c_indexed: cover property (clk_en_i && op_valid_i && ext_en_r && !op_access_sel_i);
  c_banked:  cover property (clk_en_i && op_valid_i && op_access_sel_i);
  c_wrap:    cover property (clk_en_i && op_valid_i && fp_r == 12'hfff && op_file_i != 8'h00);
  c_high_lit: cover property (clk_en_i && op_valid_i && ext_en_r && !op_access_sel_i
                              && op_file_i > OFFSET_LIMIT);
  c_freeze:  cover property (!clk_en_i && op_valid_i);

endmodule : ioag_top

// ==== sim/tb_indexed_offset_address_gen.sv ====
// Self-checking bench for the indexed offset address generator
module tb_indexed_offset_address_gen
  import ioag_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Signals and bench state
  // ****************************************************************
  logic                   ref_clk_i;       // 20 MHz clock
  logic                   rst_n_i;         // Sync reset, low
  logic                   clk_en_i;        // Clock enable
  logic                   op_valid_i;      // Operand strobe
  logic                   op_is_byte_i;    // Byte or bit op
  logic [FILE_W-1:0]      op_file_i;       // File operand
  logic                   op_access_sel_i; // Access select
  logic                   op_dest_i;       // Destination bit
  logic [3:0]             reg_addr_i;      // Register index
  logic [7:0]             reg_wdata_i;     // Write data
  logic                   reg_wr_i;        // Write strobe
  logic                   reg_rd_i;        // Read strobe
  logic [7:0]             reg_rdata_o;     // Read data
  logic                   addr_valid_o;    // Address strobe
  logic [DATA_ADDR_W-1:0] addr_o;          // Effective address
  logic                   dest_file_o;     // Destination to file
  logic                   indexed_o;       // Pointer relative
  logic                   ext_en_o;        // Extension on
  int                     n_errors;        // Mismatches
  int                     tests_run;       // Comparisons
  logic                   m_ext;           // Model enable bit
  logic [BANK_W-1:0]      m_bank;          // Model bank
  logic [DATA_ADDR_W-1:0] m_fp;            // Model frame pointer
  logic                   p_v;             // Operand in flight
  logic [12:0]            p_e;             // Expected {indexed, addr}
  logic                   p_dst;           // Expected destination
  logic [7:0]             v;               // Read result
  logic [31:0]            r;               // Random word
  localparam logic [7:0]  FL [4] = '{8'h05, 8'h5f, 8'h60, 8'hff}; // Edges of the split

  // Clock enable is driven so that the freeze can be exercised
  ioag_top u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .op_valid_i(op_valid_i), .op_is_byte_i(op_is_byte_i), .op_file_i(op_file_i),
    .op_access_sel_i(op_access_sel_i), .op_dest_i(op_dest_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .addr_valid_o(addr_valid_o), .addr_o(addr_o),
    .dest_file_o(dest_file_o), .indexed_o(indexed_o), .ext_en_o(ext_en_o));

  // ****************************************************************
  // Tasks and expectation functions
  // ****************************************************************
  // Clock toggles every half period of 25 ns
  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // Expected {indexed, address} from the bench's own register copy
  function automatic logic [12:0] exp_ea(input logic [7:0] f, input logic a);
    if (a)
      return {1'b0, m_bank, f};
    if (m_ext && f <= OFFSET_LIMIT)
      return {1'b1, m_fp + {4'h0, f}}; // Sum kept at 12 bits, carry lost
    return {1'b0, (f >= ACCESS_SPLIT) ? ACCESS_HI_BANK : ACCESS_LO_BANK, f};
  endfunction : exp_ea

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    // Outputs launched by this edge settle before anyone looks at them
    #1;
    // A write under a low clock enable is not taken
    if (clk_en_i)
    begin
      if (a == REG_CFG) m_ext = d[CFG_XEN_BIT];
      if (a == REG_BANK) m_bank = d[BANK_W-1:0];
      if (a == REG_FP_LO) m_fp[7:0] = d;
      if (a == REG_FP_HI) m_fp[11:8] = d[3:0];
    end
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : reg_rd

  // Checks the operand launched one edge earlier
  task automatic check_prev;
    if (p_v)
    begin
      chk(16'(addr_valid_o), 16'h1);
      chk(16'(addr_o), 16'(p_e[11:0]));
      chk(16'(indexed_o), 16'(p_e[12]));
      chk(16'(dest_file_o), 16'(p_dst));
    end
  endtask : check_prev

  // Operands go back to back, one per edge
  task automatic op_go(input logic [7:0] f, input logic a, input logic d, input logic b);
    @(posedge ref_clk_i);
    op_valid_i      <= 1'b1;
    op_file_i       <= f;
    op_access_sel_i <= a;
    op_dest_i       <= d;
    op_is_byte_i    <= b;
    #1 check_prev();
    p_v = 1'b1;
    p_e = exp_ea(f, a);
    p_dst = b ? d : 1'b1;
  endtask : op_go

  task automatic op_end;
    @(posedge ref_clk_i);
    op_valid_i <= 1'b0;
    #1 check_prev();
    p_v = 1'b0;
  endtask : op_end

  // Split edges crossed with a and byte or bit form; d follows the low bit of the edge index
  task automatic run_table;
    for (int i = 0; i < 16; i++)
      op_go(FL[i[1:0]], i[2], i[0], i[3]);
    op_end();
  endtask : run_table

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    {rst_n_i, op_valid_i, op_is_byte_i, op_access_sel_i, op_dest_i} = '0;
    {reg_wr_i, reg_rd_i, op_file_i, reg_addr_i, reg_wdata_i} = '0;
    {n_errors, tests_run, m_ext, m_bank, m_fp, p_v, p_e, p_dst} = '0;
    clk_en_i = 1'b1;
    r = $urandom(38);
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    // Registers come up with the extension off
    for (int i = 0; i < 4; i++)
    begin
      reg_rd(i[3:0], v);
      chk(16'(v), 16'h0);
    end
    reg_rd(4'h9, v);
    chk(16'(v), 16'h0);
    chk(16'(ext_en_o), 16'h0);
    reg_wr(REG_BANK, 8'h03);
    reg_rd(REG_BANK, v);
    chk(16'(v), 16'h03);
    // Read data stand for one cycle only
    @(posedge ref_clk_i);
    #1 chk(16'(reg_rdata_o), 16'h0);
    run_table();
    // Last operand and the dropped strobe show in the status pair
    reg_rd(REG_STATUS, v);
    chk(16'(v), 16'(p_e[7:0]));
    reg_rd(REG_STATUS_H, v);
    chk(16'(v), 16'({2'b00, p_e[12], 1'b0, p_e[11:8]}));
    reg_wr(REG_CFG, 8'h01);
    chk(16'(ext_en_o), 16'h1);
    // A low clock enable swallows a write and an operand alike
    @(posedge ref_clk_i);
    clk_en_i   <= 1'b0;
    op_valid_i <= 1'b1;
    reg_wr(REG_CFG, 8'h00);
    chk(16'(ext_en_o), 16'h1);
    chk(16'(addr_valid_o), 16'h0);
    @(posedge ref_clk_i);
    clk_en_i   <= 1'b1;
    op_valid_i <= 1'b0;
    reg_wr(REG_FP_LO, 8'h80);
    reg_rd(REG_FP_LO, v);
    chk(16'(v), 16'h80);
    run_table();
    // Zero pointer must land on the plain access locations
    reg_wr(REG_FP_LO, 8'h00);
    run_table();
    // Pointer near the top wraps inside the data space
    reg_wr(REG_FP_LO, 8'hfe);
    reg_wr(REG_FP_HI, 8'h0f);
    reg_rd(REG_FP_HI, v);
    chk(16'(v), 16'h0f);
    run_table();
    reg_wr(REG_CFG, 8'h00);
    chk(16'(ext_en_o), 16'h0);
    run_table();
    repeat (20)
    begin
      r = $urandom();
      reg_wr({2'b00, r[9:8]}, r[7:0]);
      repeat (10)
      begin
        r = $urandom();
        op_go(r[7:0], r[8], r[9], r[10]);
      end
      op_end();
    end
    end_sim();
  end

  // A hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    end_sim();
  end

endmodule : tb_indexed_offset_address_gen
